// >>> verilog/ase_defines.vh
`ifndef ASE_DEFINES_VH
`define ASE_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// APB map, byte addresses
`define ASE_AW         8
`define ASE_OFF_CTRL   8'h00
`define ASE_OFF_STAT   8'h04
`define ASE_OFF_DQ0    8'h08
`define ASE_OFF_SR0    8'h0C
`define ASE_OFF_COEF   8'h10
`define ASE_OFF_COEFL  8'h2C
`define ASE_OFF_SE     8'h30
`define ASE_OFF_SEZ    8'h34
`define ASE_OFF_AP     8'h38
`define ASE_OFF_AL     8'h3C
`define ASE_OFF_YU     8'h40
`define ASE_OFF_YL     8'h44
`define ASE_OFF_Y      8'h48
`define ASE_OFF_DMS    8'h4C
`define ASE_OFF_DML    8'h50
`define ASE_OFF_FLAGS  8'h54

////////////////////////////////////////////////////////////////////////////////
// Bit positions
`define ASE_CTRL_START 0
`define ASE_CTRL_CHRST 1
`define ASE_CTRL_ADV   2
`define ASE_ST_BUSY    0
`define ASE_ST_DONE    1
`define ASE_FL_TD      0
`define ASE_FL_PK1     1
`define ASE_FL_PK2     2
`define ASE_FLT_SIGN   10
`define ASE_FLT_EXPH   9
`define ASE_FLT_EXPL   6
`define ASE_FLT_MANTH  5

////////////////////////////////////////////////////////////////////////////////
// Arithmetic constants
`define ASE_N_COEF     8
`define ASE_N_ZERO     3'h6
`define ASE_N_POLE     3'h2
`define ASE_LAST_IDX   3'h7
`define ASE_COEF_SHIFT 2
`define ASE_MANT_RND   12'h030
`define ASE_MANT_NORM  4
`define ASE_MANT_SHIFT 8
`define ASE_Q1_SHIFT   11
`define ASE_AP_DROP    2
`define ASE_AL_ONE     7'h40
`define ASE_MIX_SHIFT  6

////////////////////////////////////////////////////////////////////////////////
// Channel reset values
`define ASE_RST_COEF   16'h0000
`define ASE_RST_FLT    11'h020
`define ASE_RST_AP     10'h000
`define ASE_RST_YU     13'h0220
`define ASE_RST_YL     19'h08800
`define ASE_RST_DMS    12'h000
`define ASE_RST_DML    14'h0000
`define ASE_RST_FLAGS  3'h0

`endif

// >>> verilog/ase_float_multiply.v
`timescale 1ns/1ps
`include "ase_defines.vh"

module ase_float_multiply (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [15:0] coef,
  input  wire [10:0] smp,
  output reg  [15:0] product_q
);

  function [3:0] msb_pos;
    input [13:0] v;
    integer k;
    begin
      msb_pos = 4'h0;
      for (k = 0; k < 14; k = k + 1) begin
        if (v[k]) begin
          msb_pos = k[3:0] + 4'h1;
        end
      end
    end
  endfunction

  wire signed [15:0] c_q12;
  wire        [13:0] c_mag;
  wire        [12:0] c_neg;
  wire        [3:0]  c_exp;
  wire        [19:0] c_norm;
  wire        [5:0]  c_mant;
  wire        [11:0] m_prod;
  wire        [11:0] m_rnd;
  wire        [7:0]  mag;
  wire        [4:0]  e_sum;
  wire        [37:0] wide;
  wire signed [37:0] tc;
  wire signed [37:0] q1;
  wire               neg;

  // Coefficient truncated to Q12 first
  assign c_q12  = $signed(coef) >>> `ASE_COEF_SHIFT;
  // Negative magnitudes keep 13 bits: the most negative coefficient maps to zero
  assign c_neg  = 13'h0000 - c_q12[12:0];
  assign c_mag  = {1'b0, coef[15] ? c_neg : c_q12[12:0]};
  assign c_exp  = msb_pos(c_mag);
  assign c_norm = {c_mag, 6'h00} >> c_exp;
  assign c_mant = (c_mag == 14'h0000) ? 6'h20 : c_norm[5:0];
  // Mantissas multiply, exponents add, signs combine
  assign m_prod = c_mant * smp[`ASE_FLT_MANTH:0];
  assign m_rnd  = m_prod + `ASE_MANT_RND;
  assign mag    = m_rnd[11:`ASE_MANT_NORM];
  assign e_sum  = {1'b0, c_exp} + {1'b0, smp[`ASE_FLT_EXPH:`ASE_FLT_EXPL]};
  assign neg    = coef[15] ^ smp[`ASE_FLT_SIGN];
  assign wide   = {30'h0, mag} << e_sum;
  // Two's complement first, then one arithmetic shift; the low 16 bits wrap
  assign tc     = neg ? -$signed(wide) : $signed(wide);
  assign q1     = tc >>> (`ASE_MANT_SHIFT + `ASE_Q1_SHIFT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      product_q <= 16'h0000;
    end else begin
      product_q <= q1[15:0];
    end
  end

endmodule

// >>> verilog/ase_signal_estimator.v
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ase_defines.vh"

module ase_signal_estimator (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`ASE_AW-1:0]      paddr,
  input  wire [31:0]             pwdata,
  output wire                    pready,
  output wire                    pslverr,
  output reg  [31:0]             prdata,
  output wire                    busy,
  output wire [14:0]             signal_estimate,
  output wire [14:0]             partial_estimate
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_MULT  = 2'b01;
  localparam [1:0] ST_DRAIN = 2'b10;

  ////////////////////////////////////////////////////////////////////////////////
  // State
  reg  [15:0] coef_q [0:`ASE_N_COEF-1];
  reg  [10:0] dq_q   [1:6];
  reg  [10:0] sr_q   [1:2];
  reg  [10:0] dq0_q;
  reg  [10:0] sr0_q;
  reg  [9:0]  speed_param_delayed_q;
  reg  [12:0] fast_scale_factor_q;
  reg  [18:0] slow_scale_factor_q;
  reg  [11:0] short_term_average_q;
  reg  [13:0] long_term_average_q;
  reg  [2:0]  flags_q;
  reg  [1:0]  state_q;
  reg  [2:0]  cnt_q;
  reg         vld_q;
  reg  [2:0]  vidx_q;
  reg  [15:0] acc_q;
  reg  [14:0] se_q;
  reg  [14:0] sez_q;
  reg         done_q;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire        acc_ph   = psel & penable;
  wire        wr_en    = acc_ph & pwrite;
  wire        set_ph   = psel & ~penable;
  wire        coef_hit = (paddr >= `ASE_OFF_COEF) && (paddr <= `ASE_OFF_COEFL)
                         && (paddr[1:0] == 2'b00);
  wire [7:0]  coef_off = paddr - `ASE_OFF_COEF;
  wire [2:0]  coef_idx = coef_off[4:2];
  reg         mapped;

  always @* begin
    case (paddr)
      `ASE_OFF_CTRL,
      `ASE_OFF_STAT,
      `ASE_OFF_DQ0,
      `ASE_OFF_SR0,
      `ASE_OFF_SE,
      `ASE_OFF_SEZ,
      `ASE_OFF_AP,
      `ASE_OFF_AL,
      `ASE_OFF_YU,
      `ASE_OFF_YL,
      `ASE_OFF_Y,
      `ASE_OFF_DMS,
      `ASE_OFF_DML,
      `ASE_OFF_FLAGS: mapped = 1'b1;
      default:                      mapped = coef_hit;
    endcase
  end

  // Every register answers in its access cycle, so no wait states
  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~mapped;

  // State writes are dropped while a sample is in flight so operands stay stable
  wire        st_wr   = wr_en & (state_q == ST_IDLE);
  wire        ctrl_wr = st_wr & (paddr == `ASE_OFF_CTRL);
  wire        start   = ctrl_wr & pwdata[`ASE_CTRL_START];
  wire        chrst   = ctrl_wr & pwdata[`ASE_CTRL_CHRST];
  wire        adv     = ctrl_wr & pwdata[`ASE_CTRL_ADV] & ~pwdata[`ASE_CTRL_CHRST];

  ////////////////////////////////////////////////////////////////////////////////
  // Speed limiter and scale factor mix
  // The dropped bits never return; a limited value of 64 stands for one
  wire [7:0]  ap_q6 = speed_param_delayed_q[9:`ASE_AP_DROP];
  wire [6:0]  limited_speed_param = (ap_q6 > {1'b0, `ASE_AL_ONE}) ? `ASE_AL_ONE
                                    : ap_q6[6:0];
  wire [12:0] ylp   = slow_scale_factor_q[18:`ASE_MIX_SHIFT];
  wire [13:0] dif   = {1'b0, fast_scale_factor_q} - {1'b0, ylp};
  wire [13:0] dmag  = dif[13] ? (14'h0000 - dif) : dif;
  wire [20:0] prod  = dmag * limited_speed_param;
  wire [12:0] pmix  = prod[12+`ASE_MIX_SHIFT:`ASE_MIX_SHIFT];
  // Product taken in magnitude, sign applied after scaling
  wire [12:0] y_mix = dif[13] ? (ylp - pmix) : (ylp + pmix);

  ////////////////////////////////////////////////////////////////////////////////
  // Coefficients, indices 0-1 pole, 2-7 zero
  // A channel reset beats a coefficient write in the same cycle
  genvar g;
  generate
    for (g = 0; g < `ASE_N_COEF; g = g + 1) begin : g_coef
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          coef_q[g] <= `ASE_RST_COEF;
        end else if (chrst) begin
          coef_q[g] <= `ASE_RST_COEF;
        end else if (st_wr && coef_hit && coef_idx == g) begin
          coef_q[g] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Delayed float samples, shifted in one step on advance
  generate
    for (g = 1; g <= 6; g = g + 1) begin : g_dq
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dq_q[g] <= `ASE_RST_FLT;
        end else if (chrst) begin
          dq_q[g] <= `ASE_RST_FLT;
        end else if (adv) begin
          dq_q[g] <= (g == 1) ? dq0_q : dq_q[(g == 1) ? 1 : g - 1];
        end
      end
    end
    for (g = 1; g <= 2; g = g + 1) begin : g_sr
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sr_q[g] <= `ASE_RST_FLT;
        end else if (chrst) begin
          sr_q[g] <= `ASE_RST_FLT;
        end else if (adv) begin
          sr_q[g] <= (g == 1) ? sr0_q : sr_q[1];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Adaptation state held for the outer datapath
  // Only stored here; the update arithmetic lives outside this block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq0_q                 <= `ASE_RST_FLT;
      sr0_q                 <= `ASE_RST_FLT;
      speed_param_delayed_q <= `ASE_RST_AP;
      fast_scale_factor_q   <= `ASE_RST_YU;
      slow_scale_factor_q   <= `ASE_RST_YL;
      short_term_average_q  <= `ASE_RST_DMS;
      long_term_average_q   <= `ASE_RST_DML;
      flags_q               <= `ASE_RST_FLAGS;
    end else if (chrst) begin
      // Delay-0 floats are scratch inputs, not channel state
      speed_param_delayed_q <= `ASE_RST_AP;
      fast_scale_factor_q   <= `ASE_RST_YU;
      slow_scale_factor_q   <= `ASE_RST_YL;
      short_term_average_q  <= `ASE_RST_DMS;
      long_term_average_q   <= `ASE_RST_DML;
      flags_q               <= `ASE_RST_FLAGS;
    end else if (st_wr) begin
      case (paddr)
        `ASE_OFF_DQ0:   dq0_q                 <= pwdata[10:0];
        `ASE_OFF_SR0:   sr0_q                 <= pwdata[10:0];
        `ASE_OFF_AP:    speed_param_delayed_q <= pwdata[9:0];
        `ASE_OFF_YU:    fast_scale_factor_q   <= pwdata[12:0];
        `ASE_OFF_YL:    slow_scale_factor_q   <= pwdata[18:0];
        `ASE_OFF_DMS:   short_term_average_q  <= pwdata[11:0];
        `ASE_OFF_DML:   long_term_average_q   <= pwdata[13:0];
        `ASE_OFF_FLAGS: flags_q               <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operand selection: steps 0-5 zero section, 6-7 pole section
  reg  [15:0] op_coef;
  reg  [10:0] op_smp;
  wire [15:0] product;

  // Zero section first, so the partial estimate is complete before the poles add in
  always @* begin
    if (cnt_q < `ASE_N_ZERO) begin
      op_coef = coef_q[cnt_q + `ASE_N_POLE];
      op_smp  = dq_q[cnt_q + 3'h1];
    end else begin
      op_coef = coef_q[cnt_q - `ASE_N_ZERO];
      op_smp  = sr_q[cnt_q - 3'h5];
    end
  end

  ase_float_multiply u_float_multiply (
    .pclk      (pclk),
    .presetn   (presetn),
    .coef      (op_coef),
    .smp       (op_smp),
    .product_q (product)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and estimate_sum accumulator
  // Wraps in 16 bits by construction; saturating here would break bit-exactness
  localparam [2:0] ZERO_LAST = `ASE_N_ZERO - 3'h1;
  wire [15:0] acc_nxt = acc_q + product;
  wire        last    = (cnt_q == `ASE_LAST_IDX);
  // The product register adds one stage, so results trail the operand index
  wire        fin     = vld_q && (vidx_q == `ASE_LAST_IDX);
  reg  [1:0]  state_d;
  reg  [2:0]  cnt_d;
  reg         done_d;

  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = done_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_MULT;
          cnt_d   = 3'h0;
          done_d  = 1'b0;
        end
      end
      ST_MULT: begin
        cnt_d = cnt_q + 3'h1;
        if (last) begin
          state_d = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (fin) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      vld_q   <= 1'b0;
      vidx_q  <= 3'h0;
      acc_q   <= 16'h0000;
      se_q    <= 15'h0000;
      sez_q   <= 15'h0000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      vld_q   <= (state_q == ST_MULT);
      vidx_q  <= cnt_q;
      // A start clears the sum at the edge that arms the sequencer
      if (start) begin
        acc_q <= 16'h0000;
      end else if (vld_q) begin
        acc_q <= acc_nxt;
      end
      if (vld_q && vidx_q == ZERO_LAST) begin
        sez_q <= acc_nxt[15:1];
      end
      if (fin) begin
        se_q <= acc_nxt[15:1];
      end
    end
  end

  assign busy             = (state_q != ST_IDLE);
  assign signal_estimate  = se_q;
  assign partial_estimate = sez_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, chosen from the setup address and captured in the setup cycle
  reg  [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    if (coef_hit) begin
      rd_d = {16'h0000, coef_q[coef_idx]};
    end else begin
      case (paddr)
        `ASE_OFF_STAT:  rd_d = {30'h0, done_q, busy};
        `ASE_OFF_DQ0:   rd_d = {21'h0, dq0_q};
        `ASE_OFF_SR0:   rd_d = {21'h0, sr0_q};
        `ASE_OFF_SE:    rd_d = {17'h0, se_q};
        `ASE_OFF_SEZ:   rd_d = {17'h0, sez_q};
        `ASE_OFF_AP:    rd_d = {22'h0, speed_param_delayed_q};
        `ASE_OFF_AL:    rd_d = {25'h0, limited_speed_param};
        `ASE_OFF_YU:    rd_d = {19'h0, fast_scale_factor_q};
        `ASE_OFF_YL:    rd_d = {13'h0, slow_scale_factor_q};
        `ASE_OFF_Y:     rd_d = {19'h0, y_mix};
        `ASE_OFF_DMS:   rd_d = {20'h0, short_term_average_q};
        `ASE_OFF_DML:   rd_d = {18'h0, long_term_average_q};
        `ASE_OFF_FLAGS: rd_d = {29'h0, flags_q};
        // Control and unmapped words read zero
        default:        rd_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (set_ph && !pwrite) begin
      prdata <= rd_d;
    end
  end

endmodule

// >>> sim/ase_signal_estimator_props.sv
`timescale 1ns/1ps
module ase_signal_estimator_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  input logic        busy,
  input logic [14:0] signal_estimate,
  input logic [14:0] partial_estimate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rda = acc && !pwrite;
  ////////////////////////////////////////
  sequence s_start;
    acc && pwrite && paddr == 8'h00 && pwdata[0] && !pwdata[1] && !busy;
  endsequence
  // Counts consecutive busy cycles, so the run length needs no long repetition
  logic [3:0] busy_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len <= 4'h0;
    end else if (busy) begin
      busy_len <= busy_len + 4'h1;
    end else begin
      busy_len <= 4'h0;
    end
  end
  sequence s_run;
    ##8 busy ##1 (!busy && busy_len == 4'h9);
  endsequence
  property p_run; s_start |=> s_run; endproperty
  property p_ready; pready; endproperty
  property p_err; acc |-> pslverr == (paddr > 8'h54 || paddr[1:0] != 2'b00); endproperty
  property p_noerr; !acc |-> !pslverr; endproperty
  // Estimates may only move while a computation is in progress
  property p_hold;
    $changed(signal_estimate) || $changed(partial_estimate) |-> $past(busy);
  endproperty
  property p_ctrl; rda && paddr == 8'h00 |-> prdata == 32'h0; endproperty
  property p_al; rda && paddr == 8'h3C |-> prdata <= 32'h40; endproperty
  property p_stat;
    rda && paddr == 8'h04 |-> prdata[0] == $past(busy) && prdata[31:2] == 30'h0;
  endproperty
  property p_se;
    rda && paddr == 8'h30 && !busy && !$past(busy) |-> prdata == {17'h0, signal_estimate};
  endproperty
  property p_sez;
    rda && paddr == 8'h34 && !busy && !$past(busy) |-> prdata == {17'h0, partial_estimate};
  endproperty
  ////////////////////////////////////////
  a_run: assert property (p_run) else $error("busy window has wrong length");
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("pslverr wrong in access phase");
  a_noerr: assert property (p_noerr) else $error("pslverr outside access phase");
  a_hold: assert property (p_hold) else $error("estimate moved while idle");
  a_ctrl: assert property (p_ctrl) else $error("control word read not zero");
  a_al: assert property (p_al) else $error("limited speed above one");
  a_stat: assert property (p_stat) else $error("status busy bit wrong");
  a_se: assert property (p_se) else $error("estimate register differs from port");
  a_sez: assert property (p_sez) else $error("partial register differs from port");
endmodule
bind ase_signal_estimator ase_signal_estimator_props ase_signal_estimator_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .busy(busy), .signal_estimate(signal_estimate), .partial_estimate(partial_estimate));

// >>> sim/ase_far_end.sv
`timescale 1ns/1ps
module ase_far_end;
  // Set 0 mixes signs and exponents; set 1 pushes the running sum past 32767, into the sign bit of the 16-bit sum.
  // Coefficients keep two low zero bits so truncation by four is sign-neutral.
  logic [10:0] dq_t [2][7] = '{'{11'h020, 11'h268, 11'h572, 11'h33F, 11'h020, 11'h7A1,
                                 11'h1ED}, '{7{11'h2FF}}};
  logic [10:0] sr_t [2][7] = '{'{11'h020, 11'h37C, 11'h6A4, 11'h020, 11'h020, 11'h020,
                                 11'h020}, '{7{11'h2FF}}};
  logic [15:0] coef_t [2][8] = '{'{16'h2000, 16'hC000, 16'h4000, 16'hE000, 16'h1234,
                                   16'hF100, 16'h0800, 16'h0000}, '{8{16'h7FFC}}};
endmodule

// >>> sim/ase_signal_estimator_tb.sv
`timescale 1ns/1ps
module ase_signal_estimator_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] signal_estimate, partial_estimate;
  int          err_count = 0;
  int          n_checks = 0;
  logic [7:0]  ra [9] = '{8'h38, 8'h40, 8'h44, 8'h4C, 8'h50, 8'h54, 8'h10, 8'h2C, 8'h08};
  logic [31:0] rv [9] = '{32'h0, 32'h220, 32'h8800, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h20};
  logic [31:0] rm [9] = '{32'h3FF, 32'h1FFF, 32'h7FFFF, 32'hFFF, 32'h3FFF, 32'h7, 32'hFFFF,
                          32'hFFFF, 32'h7FF};
  logic [9:0]  apv [6] = '{10'h000, 10'h0FF, 10'h100, 10'h103, 10'h104, 10'h3FF};

  ase_signal_estimator ase_signal_estimator_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .busy(busy), .signal_estimate(signal_estimate),
    .partial_estimate(partial_estimate));
  ase_far_end ase_far_end_i ();

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      err_count++;
      complete_run();
    end
  endtask

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(a, 1'b0, 32'h0);
    chk(nm, ex, rd);
  endtask

  // Reference product: sign applied before the shift, as the datapath rounds
  function automatic logic [15:0] fmul(input logic [15:0] c, input logic [10:0] f);
    logic [12:0] mag;
    logic [4:0]  ce;
    logic [5:0]  cm;
    logic [11:0] m;
    logic [63:0] full;
    mag = c[15] ? 13'((-c) >> 2) : 13'(c >> 2);
    ce = 5'h0;
    for (int k = 0; k < 13; k++)
      if (mag[k]) ce = 5'(k + 1);
    cm = (mag == 13'h0) ? 6'd32 : 6'({mag, 6'b0} >> ce);
    m = ({6'b0, cm} * f[5:0] + 12'd48) >> 4;
    full = 64'(m) << (ce + 5'(f[9:6]));
    if (c[15] ^ f[10]) full = -full;
    return 16'($signed(full) >>> 19);
  endfunction

  task run_set(input int s);
    logic [15:0] sez, se;
    logic [15:0] c [8];
    logic [10:0] d [7], r [7];
    int k;
    c = ase_far_end_i.coef_t[s];
    d = ase_far_end_i.dq_t[s];
    r = ase_far_end_i.sr_t[s];
    for (int i = 6; i >= 1; i--) begin
      apb(8'h08, 1'b1, {21'h0, d[i]});
      apb(8'h0C, 1'b1, {21'h0, r[i]});
      apb(8'h00, 1'b1, 32'h4);
    end
    sez = 16'h0;
    for (int i = 0; i < 8; i++) apb(8'(8'h10 + 4 * i), 1'b1, {16'h0, c[i]});
    for (int i = 2; i < 8; i++) sez += fmul(c[i], d[i - 1]);
    se = sez + fmul(c[0], r[1]) + fmul(c[1], r[2]);
    apb(8'h00, 1'b1, 32'h1);
    k = 0;
    do begin
      apb(8'h04, 1'b0, 32'h0);
      k++;
    end while (rd[1:0] !== 2'b10 && k < 30);
    if (k >= 30) begin
      err_count++;
      complete_run();
    end
    rd_chk("partial estimate", 8'h34, {17'h0, sez[15:1]});
    rd_chk("full estimate", 8'h30, {17'h0, se[15:1]});
    chk("estimate port", {17'h0, se[15:1]}, {17'h0, signal_estimate});
    chk("partial port", {17'h0, sez[15:1]}, {17'h0, partial_estimate});
    $display("test sample set %0d done", s);
  endtask
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk("reset value", ra[i], rv[i]);
    rd_chk("control read", 8'h00, 32'h0);
    chk("estimate at reset", 32'h0, {17'h0, signal_estimate});
    for (int i = 0; i < 9; i++) begin
      apb(ra[i], 1'b1, 32'hFFFFFFFF);
      rd_chk("field width", ra[i], rm[i]);
    end
    apb(8'h00, 1'b1, 32'h2);
    for (int i = 0; i < 8; i++) rd_chk("channel reset", ra[i], rv[i]);
    rd_chk("input float kept", 8'h08, 32'h7FF);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      apb(8'h38, 1'b1, {22'h0, apv[i]});
      rd_chk("limited speed", 8'h3C, 32'((apv[i] >> 2) > 10'd64 ? 10'd64 : apv[i] >> 2));
    end
    apb(8'h40, 1'b1, 32'h300);
    rd_chk("mix at full speed", 8'h48, 32'h300);
    apb(8'h38, 1'b1, 32'h0);
    rd_chk("mix at zero speed", 8'h48, 32'h220);
    rd_chk("unmapped data", 8'h58, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    rd_chk("unaligned data", 8'h02, 32'h0);
    chk("unaligned error", 32'h1, {31'h0, er});
    $display("test speed and map done");
    run_set(0);
    run_set(1);
    complete_run();
  end
endmodule
